// ### hdl/reader_host_request_framer.sv
// Function
// - Frame opens 01; check excludes start
// - Length counts bytes before check byte
// - 48: charge-up burst only, no check
// - 6C: check, charge-up and programming bursts
// - 4C: check, charge-up burst only
// - First data byte: charge-up burst ms
// - Next byte: programming burst ms
// - Count byte gives transponder data bytes
// - General read uses address 08
// - Program uses address 09
// - Lock: 6C with address 0A
// - Selective read: address 0B, four bytes
// - Selective address three bytes, LSB first
// - Program: eight data, two check bytes
// - Selective program carries fourteen bytes
`timescale 1ns/1ps
`default_nettype none
module reader_host_request_framer (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   output logic frame_done,
   output logic frame_error,
   output logic [7:0] burst1_ms,
   output logic [7:0] burst2_ms,
   output logic burst2_en,
   output logic frame_level_check,
   output var req_frame_pkg::frame_op_t op,
   output logic [7:0] page_addr,
   output logic [23:0] sel_addr,
   output logic [63:0] prog_data,
   output logic [15:0] payload_data_check,
   output logic busy
);
   import req_frame_pkg::*;

   // ==========================================
   // State
   frame_state_t st_ff, nxt_st;
   logic [7:0] len_ff, seen_ff, cnt_ff, cmd_ff, addr_ff;
   logic [4:0] idx_ff;
   logic [7:0] b1_ff, b2_ff;
   logic [23:0] sa_ff;
   logic [63:0] pd_ff;
   logic [15:0] dc_ff;
   logic done_ff, err_ff;
   logic [7:0] xsum;

   // ==========================================
   // Decode
   wire take = rx_valid;
   wire in_frame = (st_ff != ST_IDLE);
   wire acc_clear = take && (st_ff == ST_IDLE);
   wire acc_add = take && in_frame && (st_ff != ST_CHECK);
   wire cmd_ok = (rx_byte == CMD_BURST1_NOCHK) || (rx_byte == CMD_BURST12_CHK) ||
                 (rx_byte == CMD_BURST1_CHK);
   wire has_b2 = (cmd_ff == CMD_BURST12_CHK);
   wire [7:0] seen_n = seen_ff + 8'h01;
   // Data index inside the payload, address byte is index 0
   wire [4:0] idx_n = idx_ff + ONE;
   wire last_data = (idx_n == cnt_ff[4:0]);
   wire chk_ok = (rx_byte == xsum);
   // length must match bytes counted before check byte
   wire len_ok = (seen_ff == len_ff);

   function automatic frame_op_t classify(input logic [7:0] cmd, input logic [7:0] adr,
                                          input logic [7:0] cnt);
      classify = OP_NONE;
      if (adr == ADDR_READ_PG2 && cnt == CNT_GEN_READ && cmd != CMD_BURST12_CHK)
         classify = OP_GEN_READ;
      else if (adr == ADDR_PROG_PG2 && cnt == CNT_PROG && cmd == CMD_BURST12_CHK)
         classify = OP_PROG;
      else if (adr == ADDR_PROG_PG2 && cnt == CNT_SEL_PROG && cmd == CMD_BURST12_CHK)
         classify = OP_SEL_PROG;
      else if (adr == ADDR_LOCK_PG2 && cnt == CNT_GEN_READ && cmd == CMD_BURST12_CHK)
         classify = OP_LOCK;
      else if (adr == ADDR_SREAD_PG2 && cnt == CNT_SEL_READ)
         classify = OP_SEL_READ;
   endfunction

   wire frame_op_t op_now = classify(cmd_ff, addr_ff, cnt_ff);
   wire sel_form = (cnt_ff == CNT_SEL_READ) || (cnt_ff == CNT_SEL_PROG);
   wire [4:0] sa_end = sel_form ? SEL_ADDR_BYTES : ZERO5;
   wire [4:0] pd_end = sa_end + PROG_DATA_BYTES;

   frame_xor_acc u_acc (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clear(acc_clear),
      .add(acc_add),
      .din(rx_byte),
      .sum(xsum)
   );

   // ==========================================
   // Next state
   always_comb begin
      nxt_st = st_ff;
      if (take) begin
         case (st_ff)
            ST_IDLE: nxt_st = (rx_byte == START_BYTE) ? ST_LEN : ST_IDLE;
            ST_LEN: nxt_st = ST_CMD;
            ST_CMD: nxt_st = cmd_ok ? ST_BURST1 : ST_IDLE;
            ST_BURST1: nxt_st = has_b2 ? ST_BURST2 : ST_COUNT;
            ST_BURST2: nxt_st = ST_COUNT;
            ST_COUNT: nxt_st = (rx_byte == ZERO8) ? ST_CHECK : ST_DATA;
            ST_DATA: nxt_st = last_data ? ST_CHECK : ST_DATA;
            ST_CHECK: nxt_st = ST_IDLE;
            default: nxt_st = ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_IDLE;
         len_ff <= ZERO8;
         seen_ff <= ZERO8;
         cnt_ff <= ZERO8;
         cmd_ff <= ZERO8;
         addr_ff <= ZERO8;
         idx_ff <= ZERO5;
         b1_ff <= ZERO8;
         b2_ff <= ZERO8;
         sa_ff <= '0;
         pd_ff <= '0;
         dc_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         if (take && st_ff == ST_LEN) begin
            len_ff <= rx_byte;
            seen_ff <= ZERO8;
         end else if (take && in_frame && st_ff != ST_CHECK) begin
            seen_ff <= seen_n;
         end
         if (take && st_ff == ST_CMD) cmd_ff <= rx_byte;
         if (take && st_ff == ST_BURST1) b1_ff <= rx_byte;
         if (take && st_ff == ST_BURST2) b2_ff <= rx_byte;
         else if (take && st_ff == ST_CMD) b2_ff <= ZERO8;
         if (take && st_ff == ST_COUNT) begin
            cnt_ff <= rx_byte;
            idx_ff <= ZERO5;
         end
         if (take && st_ff == ST_DATA) begin
            idx_ff <= idx_n;
            if (idx_ff == ZERO5) addr_ff <= rx_byte;
            else if (idx_ff <= sa_end) sa_ff <= {rx_byte, sa_ff[23:8]};
            else if (idx_ff <= pd_end) pd_ff <= {rx_byte, pd_ff[63:8]};
            else dc_ff <= {rx_byte, dc_ff[15:8]};
         end
      end
   end

   // ==========================================
   // Result strobes, one cycle after the check byte or after a rejected command byte
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         done_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         done_ff <= take && st_ff == ST_CHECK && chk_ok && len_ok && op_now != OP_NONE;
         err_ff <= take && ((st_ff == ST_CHECK && !(chk_ok && len_ok && op_now != OP_NONE))
                   || (st_ff == ST_CMD && !cmd_ok));
      end
   end

   // Outputs other than busy are the captured fields; valid when frame_done pulses
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         burst1_ms <= ZERO8;
         burst2_ms <= ZERO8;
         burst2_en <= 1'b0;
         frame_level_check <= 1'b0;
         op <= OP_NONE;
         page_addr <= ZERO8;
         sel_addr <= '0;
         prog_data <= '0;
         payload_data_check <= '0;
         busy <= 1'b0;
      end else begin
         busy <= (nxt_st != ST_IDLE);
         if (take && st_ff == ST_CHECK && chk_ok && len_ok && op_now != OP_NONE) begin
            burst1_ms <= b1_ff;
            burst2_ms <= b2_ff;
            burst2_en <= has_b2;
            frame_level_check <= (cmd_ff != CMD_BURST1_NOCHK);
            op <= op_now;
            page_addr <= addr_ff;
            sel_addr <= sa_ff;
            prog_data <= pd_ff;
            payload_data_check <= dc_ff;
         end
      end
   end

   assign frame_done = done_ff;
   assign frame_error = err_ff;
endmodule // reader_host_request_framer
`default_nettype wire

// ### hdl/req_frame_pkg.sv
package req_frame_pkg;
   localparam logic [7:0] START_BYTE = 8'h01;
   localparam logic [7:0] CMD_BURST1_NOCHK = 8'h48;
   localparam logic [7:0] CMD_BURST12_CHK = 8'h6c;
   localparam logic [7:0] CMD_BURST1_CHK = 8'h4c;
   localparam logic [7:0] ADDR_READ_PG2 = 8'h08;
   localparam logic [7:0] ADDR_PROG_PG2 = 8'h09;
   localparam logic [7:0] ADDR_LOCK_PG2 = 8'h0a;
   localparam logic [7:0] ADDR_SREAD_PG2 = 8'h0b;
   localparam logic [7:0] CNT_GEN_READ = 8'h01;
   localparam logic [7:0] CNT_SEL_READ = 8'h04;
   localparam logic [7:0] CNT_PROG = 8'h0b;
   localparam logic [7:0] CNT_SEL_PROG = 8'h0e;
   localparam logic [4:0] PROG_DATA_BYTES = 5'd8;
   localparam logic [4:0] SEL_ADDR_BYTES = 5'd3;
   localparam logic [4:0] CHECK_BYTES = 5'd2;
   localparam logic [4:0] ONE = 5'd1;
   localparam logic [4:0] ZERO5 = 5'd0;
   localparam logic [7:0] ZERO8 = 8'h00;
   typedef enum logic [3:0] {
      ST_IDLE, ST_LEN, ST_CMD, ST_BURST1, ST_BURST2, ST_COUNT, ST_DATA, ST_CHECK
   } frame_state_t;
   typedef enum logic [2:0] {
      OP_NONE, OP_GEN_READ, OP_PROG, OP_LOCK, OP_SEL_READ, OP_SEL_PROG
   } frame_op_t;
endpackage

// ### hdl/frame_xor_acc.sv
`timescale 1ns/1ps
`default_nettype none
module frame_xor_acc (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic add,
   input wire logic [7:0] din,
   output logic [7:0] sum
);
   import req_frame_pkg::*;
   // ==========================================
   // Running xor of the bytes after start byte
   logic [7:0] acc_ff;
   logic [7:0] nxt_acc;
   assign nxt_acc = clear ? ZERO8 : (add ? (acc_ff ^ din) : acc_ff);
   assign sum = acc_ff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= ZERO8;
      end else begin
         acc_ff <= nxt_acc;
      end
   end
endmodule // frame_xor_acc
`default_nettype wire

// ### tb/framer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module framer_sva
   import req_frame_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic frame_done,
   input wire logic frame_error,
   input wire logic [7:0] burst1_ms,
   input wire logic [7:0] burst2_ms,
   input wire logic burst2_en,
   input wire logic frame_level_check,
   input wire frame_op_t op,
   input wire logic [7:0] page_addr,
   input wire logic [23:0] sel_addr,
   input wire logic [63:0] prog_data,
   input wire logic [15:0] payload_data_check,
   input wire logic busy
);
   // ==========
   // Framing and decode properties
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence open_s;
      !busy && rx_valid && rx_byte == START_BYTE;
   endsequence
   sequence noise_s;
      !busy && rx_valid && rx_byte != START_BYTE;
   endsequence
   sequence ok_s;
      frame_done ##1 !frame_done;
   endsequence
   start_open_a: assert property (open_s |=> busy) else $error("start not taken");
   noise_idle_a: assert property (noise_s |=> !busy) else $error("noise opened frame");
   done_busy_a: assert property (frame_done |-> $past(busy)) else $error("done outside frame");
   pulse_once_a: assert property (frame_done |-> ok_s) else $error("done not a pulse");
   read_addr_a: assert property (
      frame_done && op == OP_GEN_READ |-> page_addr == ADDR_READ_PG2)
      else $error("read address wrong");
   prog_addr_a: assert property (
      frame_done && (op == OP_PROG || op == OP_SEL_PROG)
      |-> page_addr == ADDR_PROG_PG2 && burst2_en) else $error("program decode wrong");
   lock_addr_a: assert property (
      frame_done && op == OP_LOCK
      |-> page_addr == ADDR_LOCK_PG2 && burst2_en) else $error("lock decode wrong");
   sel_read_a: assert property (
      frame_done && op == OP_SEL_READ |-> page_addr == ADDR_SREAD_PG2)
      else $error("selective read wrong");
   no_burst2_a: assert property (
      frame_done && !burst2_en |-> burst2_ms == 8'h00)
      else $error("stale burst time");
   done_err_excl_a: assert property (!(frame_done && frame_error))
      else $error("done and error together");
endmodule // framer_sva
`default_nettype wire

// ### tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk_sys,
   output logic rx_valid,
   output logic [7:0] rx_byte
);
   logic [7:0] f[$];
   logic [7:0] x;
   // ==========
   // One stray byte, then a whole request; bad flips bit 0 of the check byte
   // Skew offsets the length byte while the check byte stays right
   task automatic send(input logic [7:0] c, b1, b2, input logic [7:0] d[$], input logic bad,
      input logic [7:0] skew);
      f = {8'h5a, 8'h01, 8'h00, c, b1};
      if (c == 8'h6c)
         f.push_back(b2);
      f.push_back(8'(d.size()));
      f = {f, d};
      f[2] = 8'(f.size() - 3) + skew;
      x = 8'h00;
      foreach (f[i]) if (i > 1) x ^= f[i];
      f.push_back(x ^ {7'h0, bad});
      foreach (f[i]) begin
         @(negedge clk_sys);
         rx_valid = 1'b1;
         rx_byte = f[i];
      end
      @(negedge clk_sys);
      rx_valid = 1'b0;
      rx_byte = ~rx_byte;
   endtask
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
   end
endmodule // host_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import req_frame_pkg::*;
   logic clk_sys, rst_n, rx_valid, frame_done, frame_error, burst2_en, frame_level_check, busy;
   logic [7:0] rx_byte, burst1_ms, burst2_ms, page_addr, b1, b2, c;
   logic [23:0] sel_addr, sa;
   logic [63:0] prog_data, pd;
   logic [15:0] payload_data_check, dc;
   frame_op_t op, o;
   logic [7:0] d[$];
   int err_count, num_checks, ndone, nerr, k;
   // ==========
   // Clock, answer counters, watchdog
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (frame_done === 1'b1) ndone++;
      if (frame_error === 1'b1) nerr++;
   end
   initial begin
      #1000000;
      err_count++;
      tally_and_finish;
   end
   host_model host (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_byte(rx_byte));
   reader_host_request_framer uut (.clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .frame_done(frame_done), .frame_error(frame_error),
      .burst1_ms(burst1_ms), .burst2_ms(burst2_ms), .burst2_en(burst2_en),
      .frame_level_check(frame_level_check), .op(op), .page_addr(page_addr),
      .sel_addr(sel_addr), .prog_data(prog_data),
      .payload_data_check(payload_data_check), .busy(busy));
   // ==========
   // Helpers
   task chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Payload for an operation, multi-byte fields low byte first
   task automatic mk(input frame_op_t t, output logic [7:0] cm);
      d = {};
      cm = t == OP_GEN_READ ? CMD_BURST1_NOCHK :
         t == OP_SEL_READ ? CMD_BURST1_CHK : CMD_BURST12_CHK;
      d.push_back(t == OP_GEN_READ ? ADDR_READ_PG2 : t == OP_LOCK ? ADDR_LOCK_PG2 :
         t == OP_SEL_READ ? ADDR_SREAD_PG2 : ADDR_PROG_PG2);
      if (t >= OP_SEL_READ) for (int i = 0; i < 3; i++) d.push_back(sa[8*i+:8]);
      if (t == OP_PROG || t == OP_SEL_PROG) begin
         for (int i = 0; i < 8; i++) d.push_back(pd[8*i+:8]);
         d.push_back(dc[7:0]);
         d.push_back(dc[15:8]);
      end
   endtask
   task automatic run(input logic [7:0] cm, input logic flip, input logic [7:0] skew,
      input logic fail);
      int n0 = ndone;
      int e0 = nerr;
      host.send(cm, b1, b2, d, flip, skew);
      repeat (3) @(negedge clk_sys);
      chk(ndone - n0, !fail);
      chk(nerr - e0, fail);
      if (!fail) begin
         chk(op, o);
         chk(page_addr, d[0]);
         chk(burst1_ms, b1);
         chk(burst2_ms, cm == CMD_BURST12_CHK ? b2 : 8'h00);
         chk(frame_level_check, cm != CMD_BURST1_NOCHK);
         chk(burst2_en, cm == CMD_BURST12_CHK);
         if (cm == CMD_BURST1_CHK) chk({burst2_en, frame_level_check}, 2'b01);
         if (o >= OP_SEL_READ) chk(sel_addr, sa);
         if (o == OP_PROG || o == OP_SEL_PROG) chk(prog_data, pd);
         if (o == OP_PROG || o == OP_SEL_PROG) chk(payload_data_check, dc);
      end
      $display("test done op %0d fail %0d", o, fail);
   endtask
   // ==========
   // Every operation with random fields, one corrupted check, one bad command
   initial begin
      rst_n = 1'b0;
      void'($urandom(42506));
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      for (k = 0; k < 12; k++) begin
         o = frame_op_t'(k % 5 + 1);
         b1 = k == 5 ? 8'hff : 8'($urandom);
         b2 = k == 6 ? 8'h00 : 8'($urandom);
         sa = 24'($urandom);
         pd = {$urandom, $urandom};
         dc = 16'($urandom);
         mk(o, c);
         run(c, k == 10, 8'(k == 11), k >= 10);
      end
      // Bad command; no 01 follows it, so the idle framer gives one error only
      b1 = 8'h32;
      sa = 24'h123456;
      mk(OP_SEL_READ, c);
      run(8'h55, 1'b0, 8'h00, 1'b1);
      // Address byte that no payload form takes
      d = {8'h07};
      run(CMD_BURST1_CHK, 1'b0, 8'h00, 1'b1);
      rst_n = 1'b0;
      @(negedge clk_sys);
      rst_n = 1'b1;
      chk({busy, frame_done, op}, 5'h00);
      // Recovery after reset with the plain page read
      o = OP_GEN_READ;
      mk(o, c);
      run(c, 1'b0, 8'h00, 1'b0);
      tally_and_finish;
   end
endmodule // tb
bind reader_host_request_framer framer_sva sva_i (.clk_sys(clk_sys), .rst_n(rst_n),
   .rx_valid(rx_valid), .rx_byte(rx_byte), .frame_done(frame_done), .frame_error(frame_error),
   .burst1_ms(burst1_ms), .burst2_ms(burst2_ms), .burst2_en(burst2_en),
   .frame_level_check(frame_level_check), .op(op), .page_addr(page_addr), .sel_addr(sel_addr),
   .prog_data(prog_data), .payload_data_check(payload_data_check), .busy(busy));
`default_nettype wire
